// ### sfe_pkg.sv
package sfe_pkg;

  // ==========================================================================
  // opcodes seen on the serial link
  localparam logic [7:0] OPC_SECTOR_ERASE = 8'h20; // sector_erase_cmd
  localparam logic [7:0] OPC_HALF_BLOCK_ERASE = 8'h52; // half_block_erase_cmd
  localparam logic [7:0] OPC_FULL_BLOCK_ERASE = 8'hd8; // full_block_erase_cmd
  localparam logic [7:0] OPC_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0] OPC_CHIP_ERASE_B = 8'hc7;
  localparam logic [7:0] OPC_PAGE_WRITE = 8'h02; // page_write_cmd
  localparam logic [7:0] OPC_MODE_RESET = 8'hff;

  // ==========================================================================
  // frame layout: byte counter values and bit steps
  localparam logic [2:0] CNT_OPC_ONLY = 3'h1;
  localparam logic [2:0] CNT_ADDR_DONE = 3'h4;
  localparam logic [2:0] CNT_DATA = 3'h5;
  localparam logic [2:0] STEP_ONE_LINE = 3'h1;
  localparam logic [2:0] STEP_FOUR_LINE = 3'h4;
  localparam logic [3:0] RESET_CLOCKS = 4'h8;

  // ==========================================================================
  // array geometry
  localparam int ADDR_W = 23;
  localparam int SECTOR_LSB = 12;
  localparam int HALF_BLOCK_LSB = 15;
  localparam int FULL_BLOCK_LSB = 16;
  localparam int PAGE_LSB = 8;
  localparam int PAGE_BYTES = 256;
  localparam logic [7:0] BLOCK_COUNT = 8'h80;
  localparam logic [3:0] PROT_ALL_LEVEL = 4'h8;

  // ==========================================================================
  // timing: clock period and default self-timed cycle lengths
  localparam int CLK_PERIOD_NS = 50;
  localparam int SECTOR_ERASE_TIME_US = 1000;
  localparam int HALF_BLOCK_ERASE_TIME_US = 2000;
  localparam int FULL_BLOCK_ERASE_TIME_US = 4000;
  localparam int WHOLE_ARRAY_ERASE_TIME_US = 50000;
  localparam int PAGE_WRITE_TIME_US = 100;

  // ==========================================================================
  // types
  typedef enum logic [2:0] {
    SFE_OP_NONE,
    SFE_OP_SECTOR,
    SFE_OP_HALF_BLOCK,
    SFE_OP_FULL_BLOCK,
    SFE_OP_CHIP,
    SFE_OP_PAGE
  } sfe_op_kind_t;

  typedef struct packed {
    sfe_op_kind_t kind;
    logic [ADDR_W-1:0] addr;
  } sfe_op_req_t;

  typedef struct packed {
    logic [7:0] data;
    logic written;
  } sfe_page_byte_t;

endpackage

// ### sfe_flash_seq.sv
`timescale 1ns/1ps
// Function
// [R1] one-line mode: all-ones opcode over 8 clocks leaves enhance mode
// [R2] four-line mode: all-ones on four lines for 8 clocks leaves enhance mode
// [R3] host resumes plain one-line commands after clearing enhance mode
// [R4] opcode takes 8 clocks one-line or 2 clocks four-line; upper lines ignored
// [R5] 20h sector, 52h 32K block, D8h 64K block erase, all to ones
// [R6] sector erase covers 4K bytes chosen by any address inside
// [R7] sector index is address bits from the top down to bit 12
// [R8] sector erase frame is opcode plus three address bytes
// [R9] 32K block erase hits the block holding the given address
// [R10] 64K block erase hits the block holding the given address
// [R11] erase and program run only with the write enable latch set
// [R12] erase select must rise right after last address bit, else rejected
// [R13] self-timed cycle starts at select rise; busy bit clears with latch
// [R14] protected sector or block is not erased
// [R15] 60h or C7h chip erase, no address, select rises after opcode
// [R16] chip erase only when all four protect bits are zero
// [R17] page program frame is opcode, three address bytes, data bytes
// [R18] only the last 256 data bytes are kept
// [R19] page data starts at low address byte and wraps inside the page
// [R20] unsent bytes of the page stay unchanged
// [R21] program select must rise right after a data byte, else rejected
// [R22] protected page is not programmed
// [R23] in enhance mode frames are read addresses, not opcodes
// [R24] block erase ignores address bits below 15 or 16
// [R25] new erase or program is ignored while busy
module sfe_flash_seq #(
  parameter int SECTOR_ERASE_TIME_US = sfe_pkg::SECTOR_ERASE_TIME_US,
  parameter int HALF_BLOCK_ERASE_TIME_US = sfe_pkg::HALF_BLOCK_ERASE_TIME_US,
  parameter int FULL_BLOCK_ERASE_TIME_US = sfe_pkg::FULL_BLOCK_ERASE_TIME_US,
  parameter int WHOLE_ARRAY_ERASE_TIME_US = sfe_pkg::WHOLE_ARRAY_ERASE_TIME_US,
  parameter int PAGE_WRITE_TIME_US = sfe_pkg::PAGE_WRITE_TIME_US
) (
  input wire logic clk_sys, // system clock, 20 MHz
  input wire logic rst, // synchronous reset, active high
  input wire logic link_sclk, // serial clock from the host
  input wire logic select_bar, // chip select, active low
  input wire logic [3:0] sio_in, // data lines, bit 0 is the one-line input
  input wire logic four_line_command_mode, // quasi-static mode level
  input wire logic set_write_latch_cmd, // pulse: write enable decoded
  input wire logic enhance_mode_enter, // pulse: read logic entered enhance mode
  input wire logic [3:0] protect_level, // protect_level_bit3..bit0
  input wire logic [7:0] page_rd_idx, // page buffer read index
  output sfe_pkg::sfe_page_byte_t page_rd, // page buffer byte and written flag
  output sfe_pkg::sfe_op_req_t op_req, // operation kind and base address
  output logic op_start, // pulse: array operation begins
  output logic op_done, // pulse: array operation ends
  output logic cmd_rejected, // pulse: a command frame was dropped
  output logic write_in_progress, // busy bit
  output logic write_enable_latch, // write enable latch
  output logic enhance_mode // enhance read mode active
);

  // ==========================================================================
  // cycle counts derived from the self-timed cycle lengths
  localparam int SECTOR_CYC =
    (SECTOR_ERASE_TIME_US * 1000 + sfe_pkg::CLK_PERIOD_NS - 1) / sfe_pkg::CLK_PERIOD_NS;
  localparam int HALF_CYC =
    (HALF_BLOCK_ERASE_TIME_US * 1000 + sfe_pkg::CLK_PERIOD_NS - 1) / sfe_pkg::CLK_PERIOD_NS;
  localparam int FULL_CYC =
    (FULL_BLOCK_ERASE_TIME_US * 1000 + sfe_pkg::CLK_PERIOD_NS - 1) / sfe_pkg::CLK_PERIOD_NS;
  localparam int CHIP_CYC =
    (WHOLE_ARRAY_ERASE_TIME_US * 1000 + sfe_pkg::CLK_PERIOD_NS - 1) / sfe_pkg::CLK_PERIOD_NS;
  localparam int PAGE_CYC =
    (PAGE_WRITE_TIME_US * 1000 + sfe_pkg::CLK_PERIOD_NS - 1) / sfe_pkg::CLK_PERIOD_NS;
  typedef enum logic {SFE_ST_IDLE, SFE_ST_BUSY} sfe_state_t;

  // ==========================================================================
  // link domain: frame capture on the serial clock
  logic started_q;
  logic qmode_s1_q;
  logic qmode_s2_q;
  logic busy_s1_q;
  logic busy_s2_q;
  logic [7:0] shift_q;
  logic [2:0] bit_pos_q;
  logic [2:0] byte_cnt_q;
  logic [7:0] opcode_q;
  logic [23:0] addr_q;
  logic [7:0] wr_idx_q;
  logic [3:0] clk_cnt_q;
  logic ones_q;
  logic [7:0] page_mem [sfe_pkg::PAGE_BYTES];
  logic [sfe_pkg::PAGE_BYTES-1:0] written_q;
  logic first_edge;
  logic [7:0] shift_nx;
  logic [2:0] pos_base;
  logic [2:0] pos_nx;
  logic [2:0] bcnt_base;
  logic byte_done;
  logic ones_now;
  logic data_byte;
  logic [7:0] wr_addr;
  // next-state terms for one serial clock edge
  always_comb begin
    first_edge = !started_q;
    pos_base = first_edge ? 3'h0 : bit_pos_q;
    bcnt_base = first_edge ? 3'h0 : byte_cnt_q;
    if (qmode_s2_q) begin
      shift_nx = {shift_q[3:0], sio_in}; // R4
      pos_nx = pos_base + sfe_pkg::STEP_FOUR_LINE;
      ones_now = &sio_in; // R2
    end else begin
      shift_nx = {shift_q[6:0], sio_in[0]}; // R4
      pos_nx = pos_base + sfe_pkg::STEP_ONE_LINE;
      ones_now = sio_in[0]; // R1
    end
    byte_done = (pos_nx == 3'h0);
    data_byte = byte_done && (bcnt_base >= sfe_pkg::CNT_ADDR_DONE)
      && (opcode_q == sfe_pkg::OPC_PAGE_WRITE) && !busy_s2_q;
    wr_addr = addr_q[7:0] + wr_idx_q; // R19
  end

  // frame start flag, cleared by the frame's own select
  always_ff @(posedge link_sclk or posedge select_bar) begin
    if (select_bar) begin
      started_q <= 1'b0;
    end else begin
      started_q <= 1'b1;
    end
  end

  // mode and busy levels brought onto the serial clock
  always_ff @(posedge link_sclk) begin
    qmode_s1_q <= four_line_command_mode;
    qmode_s2_q <= qmode_s1_q;
    busy_s1_q <= write_in_progress;
    busy_s2_q <= busy_s1_q;
  end

  // shifter, bit and byte counters, opcode and address capture
  always_ff @(posedge link_sclk) begin
    shift_q <= shift_nx;
    bit_pos_q <= pos_nx;
    if (byte_done) begin
      if (bcnt_base != sfe_pkg::CNT_DATA) begin
        byte_cnt_q <= bcnt_base + 3'h1;
      end else begin
        byte_cnt_q <= bcnt_base;
      end
      case (bcnt_base)
        3'h0: opcode_q <= shift_nx;
        3'h1: addr_q[23:16] <= shift_nx;
        3'h2: addr_q[15:8] <= shift_nx;
        3'h3: addr_q[7:0] <= shift_nx;
        default: ;
      endcase
    end else begin
      byte_cnt_q <= bcnt_base;
    end
  end

  // enhance-mode reset pattern: all ones for the first eight clocks
  always_ff @(posedge link_sclk) begin
    if (first_edge) begin
      clk_cnt_q <= 4'h1;
      ones_q <= ones_now; // R1 R2
    end else if (clk_cnt_q != sfe_pkg::RESET_CLOCKS) begin
      clk_cnt_q <= clk_cnt_q + 4'h1;
      ones_q <= ones_q & ones_now; // R1 R2
    end
  end

  // page buffer: wraps in the page, so only the last 256 bytes survive
  always_ff @(posedge link_sclk) begin
    if (first_edge) begin
      wr_idx_q <= 8'h00;
    end else if (data_byte) begin
      wr_idx_q <= wr_idx_q + 8'h01; // R18 R19
    end
  end

  always_ff @(posedge link_sclk) begin
    if (data_byte) begin
      page_mem[wr_addr] <= shift_nx; // R18 R19
    end
  end

  always_ff @(posedge link_sclk) begin
    if (first_edge) begin
      written_q <= '0;
    end else if (data_byte) begin
      written_q[wr_addr] <= 1'b1; // R20
    end
  end

  // ==========================================================================
  // system domain: frame end detection
  logic csb_s1_q;
  logic csb_s2_q;
  logic csb_s3_q;
  logic frame_end;
  // select synchroniser; link registers are stable once select is high
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      csb_s1_q <= 1'b1;
      csb_s2_q <= 1'b1;
      csb_s3_q <= 1'b1;
    end else begin
      csb_s1_q <= select_bar;
      csb_s2_q <= csb_s1_q;
      csb_s3_q <= csb_s2_q;
    end
  end
  // a rising select seen in the system domain closes the frame
  assign frame_end = csb_s2_q && !csb_s3_q; // R13
  // ==========================================================================
  // command decode and acceptance checks
  sfe_state_t state_q;
  logic wel_q;
  logic enhance_q;
  logic [31:0] timer_q;
  sfe_pkg::sfe_op_kind_t kind_d;
  logic [sfe_pkg::ADDR_W-1:0] base_d;
  logic [31:0] load_d;
  logic is_cmd;
  logic can_run;
  logic blk_prot;
  logic [7:0] prot_floor;
  logic byte_edge;
  // lowest protected 64K block for the current protect level
  always_comb begin
    prot_floor = sfe_pkg::BLOCK_COUNT - (8'h01 << (protect_level - 4'h1));
    if (protect_level == 4'h0) begin
      blk_prot = 1'b0;
    end else if (protect_level >= sfe_pkg::PROT_ALL_LEVEL) begin
      blk_prot = 1'b1;
    end else begin
      blk_prot = ({1'b0, addr_q[22:16]} >= prot_floor); // R14 R22
    end
  end

  // decide what a finished frame asks for
  always_comb begin
    kind_d = sfe_pkg::SFE_OP_NONE;
    base_d = '0;
    load_d = 32'h0;
    is_cmd = 1'b0;
    byte_edge = (bit_pos_q == 3'h0); // R12 R21
    can_run = frame_end && !enhance_q && (state_q == SFE_ST_IDLE) && wel_q; // R11 R23 R25
    if (opcode_q == sfe_pkg::OPC_SECTOR_ERASE) begin
      is_cmd = 1'b1;
      if (byte_edge && byte_cnt_q == sfe_pkg::CNT_ADDR_DONE && !blk_prot) begin // R8 R12 R14
        kind_d = sfe_pkg::SFE_OP_SECTOR; // R5
        base_d = {addr_q[22:sfe_pkg::SECTOR_LSB], 12'h000}; // R6 R7
        load_d = 32'(SECTOR_CYC - 1);
      end
    end else if (opcode_q == sfe_pkg::OPC_HALF_BLOCK_ERASE) begin
      is_cmd = 1'b1;
      if (byte_edge && byte_cnt_q == sfe_pkg::CNT_ADDR_DONE && !blk_prot) begin // R12 R14
        kind_d = sfe_pkg::SFE_OP_HALF_BLOCK; // R5 R9
        base_d = {addr_q[22:sfe_pkg::HALF_BLOCK_LSB], 15'h0000}; // R24
        load_d = 32'(HALF_CYC - 1);
      end
    end else if (opcode_q == sfe_pkg::OPC_FULL_BLOCK_ERASE) begin
      is_cmd = 1'b1;
      if (byte_edge && byte_cnt_q == sfe_pkg::CNT_ADDR_DONE && !blk_prot) begin // R12 R14
        kind_d = sfe_pkg::SFE_OP_FULL_BLOCK; // R5 R10
        base_d = {addr_q[22:sfe_pkg::FULL_BLOCK_LSB], 16'h0000}; // R24
        load_d = 32'(FULL_CYC - 1);
      end
    end else if (opcode_q == sfe_pkg::OPC_CHIP_ERASE_A || opcode_q == sfe_pkg::OPC_CHIP_ERASE_B) begin
      is_cmd = 1'b1;
      if (byte_edge && byte_cnt_q == sfe_pkg::CNT_OPC_ONLY && protect_level == 4'h0) begin // R15 R16
        kind_d = sfe_pkg::SFE_OP_CHIP;
        load_d = 32'(CHIP_CYC - 1);
      end
    end else if (opcode_q == sfe_pkg::OPC_PAGE_WRITE) begin
      is_cmd = 1'b1;
      if (byte_edge && byte_cnt_q == sfe_pkg::CNT_DATA && !blk_prot) begin // R17 R21 R22
        kind_d = sfe_pkg::SFE_OP_PAGE;
        base_d = {addr_q[22:sfe_pkg::PAGE_LSB], 8'h00}; // R19
        load_d = 32'(PAGE_CYC - 1);
      end
    end
    if (!can_run) begin
      kind_d = sfe_pkg::SFE_OP_NONE; // R11 R25
    end
  end

  // ==========================================================================
  // self-timed cycle state machine
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= SFE_ST_IDLE;
      timer_q <= 32'h0;
    end else begin
      case (state_q)
        SFE_ST_IDLE: begin
          if (kind_d != sfe_pkg::SFE_OP_NONE) begin
            state_q <= SFE_ST_BUSY; // R13
            timer_q <= load_d;
          end
        end
        SFE_ST_BUSY: begin
          if (timer_q == 32'h0) begin
            state_q <= SFE_ST_IDLE; // R13
          end else begin
            timer_q <= timer_q - 32'h1;
          end
        end
        default: state_q <= SFE_ST_IDLE;
      endcase
    end
  end

  // request and pulses; a frame with no whole opcode byte is no command
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      op_req <= '0;
      op_start <= 1'b0;
      op_done <= 1'b0;
      cmd_rejected <= 1'b0;
    end else begin
      op_start <= (kind_d != sfe_pkg::SFE_OP_NONE);
      op_done <= (state_q == SFE_ST_BUSY) && (timer_q == 32'h0);
      cmd_rejected <= frame_end && is_cmd && !enhance_q && (byte_cnt_q != 3'h0)
        && (kind_d == sfe_pkg::SFE_OP_NONE); // R12 R21
      if (kind_d != sfe_pkg::SFE_OP_NONE) begin
        op_req <= '{kind: kind_d, addr: base_d};
      end
    end
  end

  // busy bit follows the state machine
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      write_in_progress <= 1'b0;
    end else begin
      write_in_progress <= (kind_d != sfe_pkg::SFE_OP_NONE)
        || ((state_q == SFE_ST_BUSY) && (timer_q != 32'h0)); // R13
    end
  end
  // write enable latch: set is taken only while idle, so the completion clear wins
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wel_q <= 1'b0;
    end else if (set_write_latch_cmd && state_q == SFE_ST_IDLE) begin
      wel_q <= 1'b1;
    end else if (state_q == SFE_ST_BUSY && timer_q == 32'h0) begin
      wel_q <= 1'b0; // R13
    end
  end
  // latch level straight to its port
  assign write_enable_latch = wel_q;

  // enhance mode: entered by read logic, left by the all-ones reset frame
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      enhance_q <= 1'b0;
    end else if (enhance_mode_enter) begin
      enhance_q <= 1'b1; // R23
    end else if (frame_end && ones_q && clk_cnt_q == sfe_pkg::RESET_CLOCKS) begin
      enhance_q <= 1'b0; // R1 R2
    end
  end
  // enhance level straight to its port
  assign enhance_mode = enhance_q;
  // ==========================================================================
  // page buffer read port for the array during a program cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      page_rd <= '0;
    end else begin
      page_rd <= '{data: page_mem[page_rd_idx], written: written_q[page_rd_idx]}; // R20
    end
  end
endmodule

// ### sfe_flash_seq_properties.sv
`timescale 1ns/1ps
// ====================
// checks on busy timing and accepted commands
module sfe_flash_seq_properties #(
  parameter int SECTOR_ERASE_TIME_US = sfe_pkg::SECTOR_ERASE_TIME_US,
  parameter int HALF_BLOCK_ERASE_TIME_US = sfe_pkg::HALF_BLOCK_ERASE_TIME_US,
  parameter int FULL_BLOCK_ERASE_TIME_US = sfe_pkg::FULL_BLOCK_ERASE_TIME_US,
  parameter int WHOLE_ARRAY_ERASE_TIME_US = sfe_pkg::WHOLE_ARRAY_ERASE_TIME_US,
  parameter int PAGE_WRITE_TIME_US = sfe_pkg::PAGE_WRITE_TIME_US
) (
  input wire logic clk_sys, // clock
  input wire logic rst, // reset
  input wire logic [3:0] protect_level, // protect bits
  input wire sfe_pkg::sfe_op_req_t op_req, // operation
  input wire logic op_start, // start pulse
  input wire logic op_done, // end pulse
  input wire logic write_in_progress, // busy
  input wire logic write_enable_latch // latch
);
  int busy_cnt_q;
  // cycles spent busy so far
  always_ff @(posedge clk_sys) begin
    busy_cnt_q <= (rst || !write_in_progress) ? 0 : busy_cnt_q + 1;
  end
  // busy length of each kind
  function automatic int busy_cycles(sfe_pkg::sfe_op_kind_t k);
    int us;
    case (k)
      sfe_pkg::SFE_OP_SECTOR: us = SECTOR_ERASE_TIME_US;
      sfe_pkg::SFE_OP_HALF_BLOCK: us = HALF_BLOCK_ERASE_TIME_US;
      sfe_pkg::SFE_OP_FULL_BLOCK: us = FULL_BLOCK_ERASE_TIME_US;
      sfe_pkg::SFE_OP_CHIP: us = WHOLE_ARRAY_ERASE_TIME_US;
      default: us = PAGE_WRITE_TIME_US;
    endcase
    return us * 1000 / sfe_pkg::CLK_PERIOD_NS;
  endfunction
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  property p_rise;
    $rose(write_in_progress) |-> op_start;
  endproperty
  a_rise: assert property (p_rise) else $error("busy without start");
  property p_latch;
    op_start |-> write_enable_latch;
  endproperty
  a_latch: assert property (p_latch) else $error("start without latch");
  property p_idle;
    op_start |-> !$past(write_in_progress);
  endproperty
  a_idle: assert property (p_idle) else $error("start while busy");
  property p_done;
    op_done |-> !write_in_progress && !write_enable_latch && $past(write_in_progress);
  endproperty
  a_done: assert property (p_done) else $error("bad end of cycle");
  property p_len;
    op_done |-> busy_cnt_q == busy_cycles(op_req.kind);
  endproperty
  a_len: assert property (p_len) else $error("wrong busy length");
  property p_sec;
    op_start && op_req.kind == sfe_pkg::SFE_OP_SECTOR |-> op_req.addr[11:0] == 12'h000;
  endproperty
  a_sec: assert property (p_sec) else $error("sector base not aligned");
  property p_blk;
    op_start |-> (op_req.kind != sfe_pkg::SFE_OP_HALF_BLOCK || op_req.addr[14:0] == 15'h0)
      && (op_req.kind != sfe_pkg::SFE_OP_FULL_BLOCK || op_req.addr[15:0] == 16'h0);
  endproperty
  a_blk: assert property (p_blk) else $error("block base not aligned");
  property p_chip;
    op_start && op_req.kind == sfe_pkg::SFE_OP_CHIP |-> protect_level == 4'h0;
  endproperty
  a_chip: assert property (p_chip) else $error("chip erase while protected");
  property p_prot;
    op_start |-> !protect_level[3];
  endproperty
  a_prot: assert property (p_prot) else $error("start with all protected");
endmodule

bind sfe_flash_seq sfe_flash_seq_properties #(
  .SECTOR_ERASE_TIME_US(SECTOR_ERASE_TIME_US),
  .HALF_BLOCK_ERASE_TIME_US(HALF_BLOCK_ERASE_TIME_US),
  .FULL_BLOCK_ERASE_TIME_US(FULL_BLOCK_ERASE_TIME_US),
  .WHOLE_ARRAY_ERASE_TIME_US(WHOLE_ARRAY_ERASE_TIME_US),
  .PAGE_WRITE_TIME_US(PAGE_WRITE_TIME_US)
) i_props (
  .clk_sys(clk_sys), .rst(rst), .protect_level(protect_level), .op_req(op_req),
  .op_start(op_start), .op_done(op_done), .write_in_progress(write_in_progress),
  .write_enable_latch(write_enable_latch)
);

// ### sfe_host_model.sv
`timescale 1ns/1ps
// ====================
// host controller on the serial link
module sfe_host_model (
  output logic link_sclk, // serial clock
  output logic select_bar, // chip select
  output logic [3:0] sio_in, // data lines
  output logic four_line_command_mode // mode level
);
  // idle link: clock low, select high
  initial begin
    link_sclk = 1'b0;
    select_bar = 1'b1;
    sio_in = 4'h0;
    four_line_command_mode = 1'b0;
  end
  // one frame msb first, then stray bits off the byte boundary
  task automatic send(input logic [7:0] b[$], input int stray);
    int n;
    logic [7:0] v;
    n = four_line_command_mode ? 4 : 1;
    select_bar = 1'b0;
    for (int i = 0; i < b.size() * 8 + stray; i += n) begin
      v = i < b.size() * 8 ? b[i / 8] << (i % 8) : 8'ha5;
      sio_in = n == 4 ? v[7:4] : {3'($urandom), v[7]};
      #16 link_sclk = 1'b1;
      #16 link_sclk = 1'b0;
    end
    #16 select_bar = 1'b1;
    sio_in = ~sio_in;
    #250;
  endtask
  // mode change; the all-ones frame also leaves enhance mode unless the switch is from four-line to one-line
  task automatic mode(input logic quad);
    logic [7:0] f[$];
    four_line_command_mode = quad;
    repeat (quad ? 4 : 1) f.push_back(8'hff);
    send(f, 0);
  endtask
endmodule

// ### tb.sv
`timescale 1ns/1ps
// ====================
// bench for the erase and program sequencer
module tb;
  typedef struct packed {
    sfe_pkg::sfe_op_kind_t kind;
    logic [22:0] addr;
    logic [22:0] mask;
  } sfe_note_t;
  localparam sfe_pkg::sfe_op_kind_t K_NO = sfe_pkg::SFE_OP_NONE;
  localparam sfe_pkg::sfe_op_kind_t K_SEC = sfe_pkg::SFE_OP_SECTOR;
  localparam sfe_pkg::sfe_op_kind_t K_HALF = sfe_pkg::SFE_OP_HALF_BLOCK;
  localparam sfe_pkg::sfe_op_kind_t K_CHIP = sfe_pkg::SFE_OP_CHIP;
  logic clk_sys;
  logic rst;
  logic latch;
  logic enter;
  logic quiet = 1'b0;
  logic [3:0] prot;
  logic [7:0] idx;
  logic link_sclk, select_bar, four_line_command_mode, op_start, op_done, cmd_rejected;
  logic write_in_progress, write_enable_latch, enhance_mode;
  logic [3:0] sio_in;
  logic [26:0] seen, want;
  sfe_pkg::sfe_page_byte_t page_rd;
  sfe_pkg::sfe_op_req_t op_req;
  int n_errors = 0;
  int num_checks = 0;
  int s;
  sfe_note_t notes[$];
  sfe_note_t cur;
  logic [7:0] dat[$];
  logic [8:0] pg[256];
  logic [7:0] opcs[5] = '{8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7};
  logic [22:0] masks[5] = '{23'h7ff000, 23'h7f8000, 23'h7f0000, 23'h0, 23'h0};
  sfe_pkg::sfe_op_kind_t kinds[5] = '{K_SEC, K_HALF, sfe_pkg::SFE_OP_FULL_BLOCK, K_CHIP, K_CHIP};

  always #25 clk_sys = ~clk_sys;

  sfe_host_model i_host (.link_sclk(link_sclk), .select_bar(select_bar), .sio_in(sio_in),
    .four_line_command_mode(four_line_command_mode));
  sfe_flash_seq #(.SECTOR_ERASE_TIME_US(2), .HALF_BLOCK_ERASE_TIME_US(1),
    .FULL_BLOCK_ERASE_TIME_US(1), .WHOLE_ARRAY_ERASE_TIME_US(1), .PAGE_WRITE_TIME_US(1)) i_dut (
    .clk_sys(clk_sys), .rst(rst), .link_sclk(link_sclk), .select_bar(select_bar),
    .sio_in(sio_in), .four_line_command_mode(four_line_command_mode),
    .set_write_latch_cmd(latch), .enhance_mode_enter(enter), .protect_level(prot),
    .page_rd_idx(idx), .page_rd(page_rd), .op_req(op_req), .op_start(op_start),
    .op_done(op_done), .cmd_rejected(cmd_rejected), .write_in_progress(write_in_progress),
    .write_enable_latch(write_enable_latch), .enhance_mode(enhance_mode));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("errors %0d checks %0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // each start or refusal is matched against the oldest note
  always @(posedge clk_sys) begin
    if (op_start === 1'b1 || cmd_rejected === 1'b1) begin
      if (notes.size() == 0) begin
        chk({op_start, cmd_rejected}, 2'b00);
      end else begin
        cur = notes.pop_front();
        seen = op_start ? {1'b1, op_req.kind, op_req.addr & cur.mask} : 27'h0;
        want = cur.kind == K_NO ? 27'h0 : {1'b1, cur.kind, cur.addr & cur.mask};
        chk(seen, want);
      end
    end
  end

  // wait until every note is answered and the cycle has ended
  task automatic idle();
    for (int i = 0; notes.size() > 0 || write_in_progress !== 1'b0; i++) begin
      if (i == 400) begin
        n_errors++;
        $display("mismatch at %0t: no answer", $time);
        final_report();
      end
      @(posedge clk_sys);
    end
  endtask

  // f[0] sets the latch first, f[1] returns without waiting
  task automatic op(input logic [7:0] opc, input logic [22:0] a, input sfe_pkg::sfe_op_kind_t k,
      input logic [22:0] m, input int na, input int stray, input logic [1:0] f);
    logic [7:0] fr[$];
    sfe_note_t nt;
    if (f[0]) begin
      @(posedge clk_sys) latch <= 1'b1;
      @(posedge clk_sys) latch <= 1'b0;
    end
    nt = '{k, a, m};
    if (quiet !== 1'b1) notes.push_back(nt);
    fr.push_back(opc);
    for (int i = 0; i < na; i++) fr.push_back(8'(a >> (16 - 8 * i)));
    fr = {fr, dat};
    i_host.send(fr, stray);
    if (!f[1]) idle();
  endtask

  // program n random bytes at a, then read back the page buffer
  task automatic pgm(input logic [22:0] a, input int n);
    dat.delete();
    foreach (pg[i]) pg[i] = 9'h0;
    for (int i = 0; i < n; i++) begin
      dat.push_back(8'($urandom));
      pg[8'(a[7:0] + i)] = {dat[i], 1'b1};
    end
    op(8'h02, a, sfe_pkg::SFE_OP_PAGE, 23'h0, 3, 0, 2'b01);
    dat.delete();
    for (int k = 0; k < 256; k++) begin
      @(posedge clk_sys) idx <= 8'(k);
      repeat (2) @(posedge clk_sys);
      chk(pg[k][0] ? page_rd : 9'(page_rd.written), pg[k]);
    end
  endtask

  initial begin
    clk_sys = 1'b0;
    rst <= 1'b1;
    latch <= 1'b0;
    enter <= 1'b0;
    prot <= 4'h0;
    idx <= 8'h00;
    void'($urandom(32'h3c50));
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    op(8'h20, 23'($urandom), K_NO, 23'h0, 3, 0, 2'b00);
    for (int j = 0; j < 10; j++) begin
      s = j / 2;
      i_host.mode(j[0]);
      op(opcs[s], 23'($urandom), kinds[s], masks[s], s < 3 ? 3 : 0, 0, 1);
    end
    i_host.mode(1'b0);
    op(8'h20, 23'h001234, K_NO, 23'h0, 3, 4, 1);
    op(8'h60, 23'h0, K_NO, 23'h0, 1, 0, 1);
    prot <= 4'h1;
    op(8'hc7, 23'h0, K_NO, 23'h0, 0, 0, 1);
    op(8'hd8, 23'h7f1234, K_NO, 23'h0, 3, 0, 1);
    op(8'h52, 23'h7e8000, K_HALF, 23'h7f8000, 3, 0, 1);
    op(8'h20, 23'h0100ab, K_SEC, 23'h7ff000, 3, 0, 3);
    op(8'h20, 23'h0100ab, K_NO, 23'h0, 3, 0, 0);
    pgm(23'h0345f0, 20);
    pgm(23'h000703, 258);
    dat.push_back(8'h5a);
    op(8'h02, 23'h000100, K_NO, 23'h0, 3, 4, 1);
    prot <= 4'h8;
    op(8'h02, 23'h000100, K_NO, 23'h0, 3, 0, 1);
    prot <= 4'h0;
    dat.delete();
    @(posedge clk_sys) enter <= 1'b1;
    @(posedge clk_sys) enter <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk(enhance_mode, 1'b1);
    quiet = 1'b1;
    op(8'h20, 23'h002000, K_NO, 23'h0, 3, 0, 1);
    quiet = 1'b0;
    i_host.mode(1'b0);
    @(posedge clk_sys) chk(enhance_mode, 1'b0);
    @(posedge clk_sys) enter <= 1'b1;
    @(posedge clk_sys) enter <= 1'b0;
    i_host.mode(1'b1);
    @(posedge clk_sys) chk(enhance_mode, 1'b0);
    i_host.mode(1'b0);
    op(8'h20, 23'h2abcde, K_SEC, 23'h7ff000, 3, 0, 1);
    final_report();
  end
endmodule
